// [fsp_status_protect_regs.sv]
// status, write-enable and protection registers of a serial flash
// assumes a command decoder on ref_clk and an array engine raising op_done
//
// Summary of operation
// [RQ1] wrap enabled at 0; window 8..64 bytes
// [RQ2] dummy field 1..15 cycles, zero disables
// [RQ3] top config bit is reserved, reads 0
// [RQ4] busy set during program, erase, status write
// [RQ5] while busy only reset, read, suspend taken
// [RQ6] busy clears when the operation finishes
// [RQ7] write enable command sets the latch
// [RQ8] latch cleared by reset and modifying commands
// [RQ9] latch cleared even when protection blocks
// [RQ10] suspend clears latch, resume sets it again
// [RQ11] protect level bits written by status write
// [RQ12] protect level resets to zero
// [RQ13] bottom bit picks range origin, resets 0
// [RQ14] status write needs latch and guard bits
// [RQ15] granularity bit picks small sectors, resets 0
// [RQ16] config written only after volatile enable
// [RQ17] program/erase on protected region ignored
// [RQ18] status reads return current register values
`timescale 1ns/100ps
`include "fsp_consts.svh"

module fsp_status_protect_regs
    import fsp_pkg::*;
(
    input  wire logic       ref_clk,
    input  wire logic       rst,
    input  wire logic       cmd_valid,
    input  wire fsp_cmd_e   cmd_code,
    input  wire logic [7:0] cmd_wdata,
    input  wire logic       target_protected,
    input  wire logic       op_done,
    input  wire logic       status_guard_hi,
    input  wire logic       write_protect_n,
    output logic      [7:0] rd_data,
    output logic            rd_valid,
    output logic            cmd_ignored,
    output logic            busy,
    output logic            write_enable_latch,
    output logic            op_start,
    output logic            op_suspend,
    output logic            op_resume,
    output logic      [2:0] protect_level,
    output logic            protect_from_bottom,
    output logic            protect_granularity_small,
    output logic            status_guard_lo,
    output logic      [1:0] wrap_length,
    output logic            wrap_disable,
    output logic      [5:0] wrap_mask,
    output logic      [3:0] read_dummy_cycles,
    output logic            latency_var_en
);

    // ==========================================================
    // state
    fsp_state_e state_q;
    fsp_state_e state_d;
    logic       busy_q;
    logic       wel_q;
    logic       vwe_q;
    logic       arr_q;
    logic [5:0] psp_nv_q;
    logic [5:0] psp_pend_q;
    logic       pend_q;
    logic [7:0] rwl_q;
    logic       wp_s1_q;
    logic       wp_s2_q;
    logic [7:0] rd_data_q;
    logic       rd_valid_q;
    logic       ign_q;
    logic       start_q;
    logic       susp_q;
    logic       res_q;
    logic [5:0] mask_q;
    logic       lat_en_q;

    // ==========================================================
    // command decode
    wire c_wren  = cmd_code == CMD_WREN;
    wire c_wrdi  = cmd_code == CMD_WRDI;
    wire c_vwren = cmd_code == CMD_VWREN;
    wire c_rd1   = cmd_code == CMD_RD_PSP;
    wire c_rd3   = cmd_code == CMD_RD_RWL;
    wire c_wpsp  = cmd_code == CMD_WR_PSP;
    wire c_wrwl  = cmd_code == CMD_WR_RWL;
    wire c_arr   = (cmd_code == CMD_PROG) || (cmd_code == CMD_ERASE);
    wire c_sreg  = (cmd_code == CMD_SREG_PRG) || (cmd_code == CMD_SREG_ERS);
    wire c_susp  = cmd_code == CMD_SUSPEND;
    wire c_res   = cmd_code == CMD_RESUME;
    wire c_rst   = cmd_code == CMD_SW_RESET;

    wire is_idle = state_q == ST_IDLE;
    wire is_busy = state_q == ST_BUSY;
    wire is_susp = state_q == ST_SUSP;

    // [RQ5] busy command filter
    wire busy_ok = c_rd1 || c_rd3 || c_susp || c_rst;
    // suspended part still needs the latch and resume
    wire susp_ok = busy_ok || c_res || c_wren || c_wrdi;
    wire take    = cmd_valid && (is_idle || (is_busy && busy_ok) || (is_susp && susp_ok));

    // [RQ14] status write guard
    wire guard_ok = !status_guard_hi && !(psp_nv_q[5] && !wp_s2_q);

    // [RQ17] protected target ignored
    wire start_arr  = take && c_arr && wel_q && !target_protected;
    wire start_sreg = take && c_sreg && wel_q;
    // [RQ11] non-volatile status write
    wire start_nvw  = take && c_wpsp && wel_q && !vwe_q && guard_ok;
    wire vol_psp    = take && c_wpsp && vwe_q && guard_ok;
    // [RQ16] config needs volatile enable
    wire vol_rwl    = take && c_wrwl && vwe_q;
    wire start_any  = start_arr || start_sreg || start_nvw;
    // [RQ6] completion ends busy
    wire finish     = is_busy && op_done;
    // finish beats a suspend landing in the same cycle
    wire do_susp    = take && c_susp && is_busy && arr_q && !op_done;
    wire do_res     = take && c_res && is_susp;
    wire sw_rst     = take && c_rst;

    wire blocked = take && ((c_arr && !start_arr) || (c_sreg && !start_sreg)
                   || (c_wpsp && !start_nvw && !vol_psp) || (c_wrwl && !vol_rwl)
                   || (c_susp && !do_susp) || (c_res && !do_res));

    // [RQ7] latch set
    wire wel_set = (take && c_wren) || do_res;
    // [RQ8] [RQ9] latch clear
    wire wel_clr = (take && (c_wrdi || c_arr || c_sreg || c_wpsp || c_wrwl)) || sw_rst
                   || do_susp;
    // set wins over clear
    wire wel_d   = wel_set || (wel_q && !wel_clr);

    wire vwe_set = take && c_vwren;
    wire vwe_clr = take && !c_vwren && !c_rd1 && !c_rd3;

    // [RQ18] live status views
    wire [7:0] psp_view = {psp_nv_q, wel_q, busy_q};
    wire [7:0] rwl_view = {1'b0, rwl_q[6:0]};

    // [RQ1] wrap window mask
    wire [6:0] win_bytes = 7'(`FSP_WRAP_MIN << rwl_q[`FSP_RWL_LEN_HI:`FSP_RWL_LEN_LO]);
    wire [5:0] mask_d    = 6'(win_bytes - 7'h01);

    // ==========================================================
    // sequencer
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ST_IDLE: begin
                // [RQ4] busy on embedded operation
                if (start_any) begin
                    state_d = ST_BUSY;
                end
            end
            ST_BUSY: begin
                if (sw_rst || finish) begin
                    state_d = ST_IDLE;
                end else if (do_susp) begin
                    state_d = ST_SUSP;
                end
            end
            ST_SUSP: begin
                if (sw_rst) begin
                    state_d = ST_IDLE;
                end else if (do_res) begin
                    state_d = ST_BUSY;
                end
            end
            default: state_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state_q <= ST_IDLE;
            busy_q  <= 1'b0;
        end else begin
            state_q <= state_d;
            busy_q  <= state_d == ST_BUSY;
        end
    end

    // ==========================================================
    // write-enable latches
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            wel_q <= 1'b0;
            vwe_q <= 1'b0;
        end else begin
            wel_q <= wel_d;
            vwe_q <= vwe_set || (vwe_q && !vwe_clr && !sw_rst);
        end
    end

    // only program/erase of the array may be suspended
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            arr_q <= 1'b0;
        end else if (start_any) begin
            arr_q <= start_arr;
        end
    end

    // ==========================================================
    // protection fields
    // [RQ12] [RQ13] [RQ15] factory zero
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            psp_nv_q <= `FSP_PSP_NV_RST;
        end else if (vol_psp) begin
            psp_nv_q <= cmd_wdata[`FSP_PSP_NV_HI:`FSP_PSP_NV_LO];
        end else if (finish && pend_q) begin
            psp_nv_q <= psp_pend_q;
        end
    end

    // non-volatile data lands only when the write completes
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            psp_pend_q <= `FSP_PSP_NV_RST;
            pend_q     <= 1'b0;
        end else if (start_nvw) begin
            psp_pend_q <= cmd_wdata[`FSP_PSP_NV_HI:`FSP_PSP_NV_LO];
            pend_q     <= 1'b1;
        end else if (finish || sw_rst) begin
            pend_q     <= 1'b0;
        end
    end

    // ==========================================================
    // wrap and latency config
    // [RQ3] reserved bit held zero
    always_ff @(posedge ref_clk) begin
        if (rst || sw_rst) begin
            rwl_q <= `FSP_RWL_RST;
        end else if (vol_rwl) begin
            rwl_q <= {1'b0, cmd_wdata[6:0]};
        end
    end

    // [RQ1] [RQ2] derived read controls
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            mask_q   <= 6'h00;
            lat_en_q <= 1'b0;
        end else begin
            mask_q   <= mask_d;
            lat_en_q <= |rwl_q[`FSP_RWL_DUMMY_HI:`FSP_RWL_DUMMY_LO];
        end
    end

    // pin is asynchronous to ref_clk
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            wp_s1_q <= 1'b1;
            wp_s2_q <= 1'b1;
        end else begin
            wp_s1_q <= write_protect_n;
            wp_s2_q <= wp_s1_q;
        end
    end

    // ==========================================================
    // answers and engine strobes
    // [RQ18] read returns live value
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rd_data_q  <= 8'h00;
            rd_valid_q <= 1'b0;
        end else begin
            rd_valid_q <= take && (c_rd1 || c_rd3);
            if (take && c_rd1) begin
                rd_data_q <= psp_view;
            end else if (take && c_rd3) begin
                rd_data_q <= rwl_view;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ign_q   <= 1'b0;
            start_q <= 1'b0;
            susp_q  <= 1'b0;
            res_q   <= 1'b0;
        end else begin
            ign_q   <= (cmd_valid && !take) || blocked;
            start_q <= start_any;
            susp_q  <= do_susp;
            res_q   <= do_res;
        end
    end

    assign rd_data                   = rd_data_q;
    assign rd_valid                  = rd_valid_q;
    assign cmd_ignored               = ign_q;
    assign busy                      = busy_q;
    assign write_enable_latch        = wel_q;
    assign op_start                  = start_q;
    assign op_suspend                = susp_q;
    assign op_resume                 = res_q;
    assign protect_level             = psp_nv_q[2:0];
    assign protect_from_bottom       = psp_nv_q[3];
    assign protect_granularity_small = psp_nv_q[4];
    assign status_guard_lo           = psp_nv_q[5];
    assign wrap_length               = rwl_q[`FSP_RWL_LEN_HI:`FSP_RWL_LEN_LO];
    assign wrap_disable              = rwl_q[`FSP_RWL_WRAP_DIS];
    assign wrap_mask                 = mask_q;
    assign read_dummy_cycles         = rwl_q[`FSP_RWL_DUMMY_HI:`FSP_RWL_DUMMY_LO];
    assign latency_var_en            = lat_en_q;

    // ==========================================================
    // checks
    AST_RSVD_ZERO: assert property (@(posedge ref_clk) disable iff (rst) // [RQ3]
        cmd_valid && is_idle && c_rd3 |=> rd_valid && !rd_data[7])
        else $error("reserved config bit read as one");

    AST_BUSY_FILTER: assert property (@(posedge ref_clk) disable iff (rst) // [RQ5]
        cmd_valid && is_busy && !busy_ok |=> cmd_ignored && $stable(write_enable_latch))
        else $error("command taken while busy");

    AST_WREN: assert property (@(posedge ref_clk) disable iff (rst) // [RQ7]
        cmd_valid && is_idle && c_wren |=> write_enable_latch && !cmd_ignored)
        else $error("latch not set by enable");

    AST_PROT_DROP: assert property (@(posedge ref_clk) disable iff (rst) // [RQ9]
        cmd_valid && is_idle && c_arr && wel_q && target_protected
        |=> !write_enable_latch && !op_start && !busy && cmd_ignored)
        else $error("protected program not dropped");

    AST_SUSPEND: assert property (@(posedge ref_clk) disable iff (rst) // [RQ10]
        do_susp |=> op_suspend && !busy && !write_enable_latch)
        else $error("suspend did not clear latch");

    AST_RESUME: assert property (@(posedge ref_clk) disable iff (rst) // [RQ10]
        do_res |=> op_resume && busy && write_enable_latch)
        else $error("resume did not restore latch");

    AST_DONE: assert property (@(posedge ref_clk) disable iff (rst) // [RQ6]
        is_busy && op_done |=> !busy)
        else $error("busy held after completion");

    AST_START_BUSY: assert property (@(posedge ref_clk) disable iff (rst) // [RQ4]
        start_any |=> busy && op_start && !write_enable_latch)
        else $error("operation start without busy");

    AST_CFG_GUARD: assert property (@(posedge ref_clk) disable iff (rst) // [RQ16]
        cmd_valid && c_wrwl && !vwe_q && !c_rst |=> $stable(rwl_q))
        else $error("config changed without volatile enable");

    AST_GUARD: assert property (@(posedge ref_clk) disable iff (rst) // [RQ14]
        cmd_valid && c_wpsp && status_guard_hi && !finish |=> $stable(psp_nv_q) && !op_start)
        else $error("guarded status write accepted");

    AST_RD_PSP: assert property (@(posedge ref_clk) disable iff (rst) // [RQ18]
        take && c_rd1 |=> rd_valid && rd_data[7:2] == $past(psp_nv_q)
        && rd_data[0] == $past(busy_q))
        else $error("status read stale");

    AST_WRAP_MASK: assert property (@(posedge ref_clk) disable iff (rst) // [RQ1]
        $stable(rwl_q) && rwl_q[6:5] == 2'b11 |=> wrap_mask == 6'h3f)
        else $error("wrap window not 64 bytes");

endmodule

// [fsp_consts.svh]
// bit positions, reset values and fixed figures of the status block
// assumes inclusion by bare name from the design
`ifndef FSP_CONSTS_SVH
`define FSP_CONSTS_SVH

// primary_status_protect field positions
`define FSP_PSP_BUSY     0
`define FSP_PSP_WRITE_EN 1
`define FSP_PSP_LEVEL_LO 2
`define FSP_PSP_LEVEL_HI 4
`define FSP_PSP_BOTTOM   5
`define FSP_PSP_SMALL    6
`define FSP_PSP_GUARD_LO 7
`define FSP_PSP_NV_LO    2
`define FSP_PSP_NV_HI    7

// read_wrap_latency_config field positions
`define FSP_RWL_DUMMY_LO 0
`define FSP_RWL_DUMMY_HI 3
`define FSP_RWL_WRAP_DIS 4
`define FSP_RWL_LEN_LO   5
`define FSP_RWL_LEN_HI   6
`define FSP_RWL_RESERVED 7

// reset values
`define FSP_PSP_NV_RST   6'h00
`define FSP_RWL_RST      8'h70

// smallest wrap window in bytes
`define FSP_WRAP_MIN     7'h08

`endif

// [fsp_pkg.sv]
// types shared by the status and protection register block
// assumes fsp_consts.svh sits in the same folder
package fsp_pkg;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_BUSY = 3'b010,
        ST_SUSP = 3'b100
    } fsp_state_e;

    typedef enum logic [3:0] {
        CMD_WREN     = 4'h0,
        CMD_WRDI     = 4'h1,
        CMD_VWREN    = 4'h2,
        CMD_RD_PSP   = 4'h3,
        CMD_RD_RWL   = 4'h4,
        CMD_WR_PSP   = 4'h5,
        CMD_WR_RWL   = 4'h6,
        CMD_PROG     = 4'h7,
        CMD_ERASE    = 4'h8,
        CMD_SREG_PRG = 4'h9,
        CMD_SREG_ERS = 4'ha,
        CMD_SUSPEND  = 4'hb,
        CMD_RESUME   = 4'hc,
        CMD_SW_RESET = 4'hd
    } fsp_cmd_e;

endpackage

// [fsp_engine_model.sv]
// array engine stand-in: answers op_start with an op_done pulse
// assumes pulses from the status block on ref_clk and a bench-set run length
`timescale 1ns/100ps

module fsp_engine_model (
    input  wire logic       ref_clk,
    input  wire logic       rst,
    input  wire logic       op_start,
    input  wire logic       op_suspend,
    input  wire logic       op_resume,
    input  wire logic [7:0] op_cycles,
    output logic            op_done
);
    logic [7:0] cnt_q;
    logic       run_q;

    // ============================================
    // operation timer
    // suspend freezes the count, so resume only finishes the rest
    always_ff @(posedge ref_clk) begin
        op_done <= 1'b0;
        if (rst) begin
            cnt_q <= 8'h00;
            run_q <= 1'b0;
        end else if (op_start) begin
            cnt_q <= op_cycles;
            run_q <= 1'b1;
        end else if (op_suspend) begin
            run_q <= 1'b0;
        end else if (op_resume) begin
            run_q <= 1'b1;
        end else if (run_q && cnt_q <= 8'h01) begin
            run_q   <= 1'b0;
            op_done <= 1'b1;
        end else if (run_q) begin
            cnt_q <= cnt_q - 8'h01;
        end
    end
endmodule

// [fsp_status_protect_regs_tb.sv]
// self-checking bench of the status and protection register block
// assumes fsp_pkg compiled first and the engine model beside the design
`timescale 1ns/100ps

module fsp_status_protect_regs_tb import fsp_pkg::*; ();
    logic       ref_clk;
    logic       rst;
    logic       cmd_valid;
    fsp_cmd_e   cmd_code;
    logic [7:0] cmd_wdata;
    logic       target_protected;
    logic       op_done;
    logic       status_guard_hi;
    logic       write_protect_n;
    logic [7:0] rd_data;
    logic       rd_valid;
    logic       cmd_ignored;
    logic       busy;
    logic       write_enable_latch;
    logic       op_start;
    logic       op_suspend;
    logic       op_resume;
    logic [2:0] protect_level;
    logic       protect_from_bottom;
    logic       protect_granularity_small;
    logic       status_guard_lo;
    logic [1:0] wrap_length;
    logic       wrap_disable;
    logic [5:0] wrap_mask;
    logic [3:0] read_dummy_cycles;
    logic       latency_var_en;
    int         n_mismatch;
    int         n_tests;

    fsp_status_protect_regs fsp_status_protect_regs_i (.*);

    // slow enough that suspend and busy reads land mid-operation
    fsp_engine_model fsp_engine_model_i (
        .ref_clk   (ref_clk),
        .rst       (rst),
        .op_start  (op_start),
        .op_suspend(op_suspend),
        .op_resume (op_resume),
        .op_cycles (8'h14),
        .op_done   (op_done)
    );

    // ============================================
    // clock and shared tasks
    always #12.5 ref_clk = ~ref_clk;

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic send(input fsp_cmd_e code, input logic [7:0] data, input logic prot);
        @(posedge ref_clk);
        cmd_valid        <= 1'b1;
        cmd_code         <= code;
        cmd_wdata        <= data;
        target_protected <= prot;
        @(posedge ref_clk);
        cmd_valid <= 1'b0;
        #1;
    endtask

    task automatic rd(input fsp_cmd_e code, input logic [7:0] exp);
        send(code, 8'h00, 1'b0);
        chk({7'h00, rd_valid}, 8'h01);
        chk(rd_data, exp);
    endtask

    task automatic wait_idle;
        int n;
        n = 0;
        while (busy !== 1'b0 && n < 200) begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        chk({7'h00, busy}, 8'h00);
    endtask

    task automatic end_sim;
        $display("tests=%0d mismatches=%0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // ============================================
    // scenarios
    task automatic t_reset;
        rd(CMD_RD_PSP, 8'h00);
        rd(CMD_RD_RWL, 8'h70);
        chk({2'b00, wrap_mask}, 8'h3f);
        chk({7'h00, latency_var_en}, 8'h00);
    endtask

    task automatic t_latch;
        send(CMD_WREN, 8'h00, 1'b0);
        chk({7'h00, write_enable_latch}, 8'h01);
        rd(CMD_RD_PSP, 8'h02);
        send(CMD_WRDI, 8'h00, 1'b0);
        chk({7'h00, write_enable_latch}, 8'h00);
    endtask

    task automatic t_nv_write;
        send(CMD_WREN, 8'h00, 1'b0);
        send(CMD_WR_PSP, 8'h7c, 1'b0);
        chk({6'h00, busy, op_start}, 8'h03);
        chk({7'h00, write_enable_latch}, 8'h00);
        send(CMD_WREN, 8'h00, 1'b0);
        chk({7'h00, cmd_ignored}, 8'h01);
        chk({7'h00, write_enable_latch}, 8'h00);
        rd(CMD_RD_PSP, 8'h01);
        wait_idle();
        rd(CMD_RD_PSP, 8'h7c);
        chk({1'b0, protect_granularity_small, protect_from_bottom, protect_level, 2'b00},
            8'h7c);
        send(CMD_WREN, 8'h00, 1'b0);
        send(CMD_WR_PSP, 8'h00, 1'b0);
        wait_idle();
        rd(CMD_RD_PSP, 8'h00);
    endtask

    task automatic t_guard;
        send(CMD_WR_PSP, 8'h1c, 1'b0);
        chk({6'h00, cmd_ignored, busy}, 8'h02);
        @(posedge ref_clk);
        status_guard_hi <= 1'b1;
        send(CMD_WREN, 8'h00, 1'b0);
        send(CMD_WR_PSP, 8'h1c, 1'b0);
        chk({6'h00, cmd_ignored, busy}, 8'h02);
        chk({7'h00, write_enable_latch}, 8'h00);
        rd(CMD_RD_PSP, 8'h00);
    endtask

    // guard stays high here: it must not shield the config register
    task automatic t_config;
        logic [3:0] dummy [4];
        logic [7:0] d;
        dummy = '{4'h0, 4'h1, 4'hf, 4'h7};
        send(CMD_WR_RWL, 8'h0f, 1'b0);
        chk({7'h00, cmd_ignored}, 8'h01);
        for (int i = 0; i < 4; i++) begin
            d = {1'b1, i[1:0], 1'b0, dummy[i]};
            send(CMD_VWREN, 8'h00, 1'b0);
            send(CMD_WR_RWL, d, 1'b0);
            chk({7'h00, busy}, 8'h00);
            @(posedge ref_clk);
            #1;
            chk({2'b00, wrap_mask}, 8'((8 << i) - 1));
            chk({3'h0, wrap_disable, read_dummy_cycles}, {4'h0, dummy[i]});
            chk({7'h00, latency_var_en}, {7'h00, dummy[i] != 4'h0});
            rd(CMD_RD_RWL, d & 8'h7f);
        end
        send(CMD_VWREN, 8'h00, 1'b0);
        send(CMD_WR_RWL, 8'h70, 1'b0);
        chk({7'h00, wrap_disable}, 8'h01);
        @(posedge ref_clk);
        status_guard_hi <= 1'b0;
    endtask

    // low guard bit only bites while the pin is low
    task automatic t_pin;
        send(CMD_WREN, 8'h00, 1'b0);
        send(CMD_WR_PSP, 8'h80, 1'b0);
        wait_idle();
        chk({7'h00, status_guard_lo}, 8'h01);
        @(posedge ref_clk);
        write_protect_n <= 1'b0;
        repeat (3) @(posedge ref_clk);
        send(CMD_WREN, 8'h00, 1'b0);
        send(CMD_WR_PSP, 8'h00, 1'b0);
        chk({6'h00, cmd_ignored, busy}, 8'h02);
        @(posedge ref_clk);
        write_protect_n <= 1'b1;
        repeat (3) @(posedge ref_clk);
        send(CMD_VWREN, 8'h00, 1'b0);
        send(CMD_WR_PSP, 8'h04, 1'b0);
        chk({6'h00, cmd_ignored, busy}, 8'h00);
        rd(CMD_RD_PSP, 8'h04);
    endtask

    task automatic t_ops;
        fsp_cmd_e ops [4];
        ops = '{CMD_PROG, CMD_ERASE, CMD_SREG_PRG, CMD_SREG_ERS};
        foreach (ops[i]) begin
            send(CMD_WREN, 8'h00, 1'b0);
            send(ops[i], 8'h00, 1'b0);
            chk({6'h00, busy, write_enable_latch}, 8'h02);
            wait_idle();
        end
        send(CMD_WREN, 8'h00, 1'b0);
        send(CMD_PROG, 8'h00, 1'b1);
        chk({6'h00, cmd_ignored, busy}, 8'h02);
        chk({7'h00, write_enable_latch}, 8'h00);
    endtask

    task automatic t_suspend;
        send(CMD_WREN, 8'h00, 1'b0);
        send(CMD_PROG, 8'h00, 1'b0);
        send(CMD_SUSPEND, 8'h00, 1'b0);
        chk({5'h00, op_suspend, busy, write_enable_latch}, 8'h04);
        send(CMD_RESUME, 8'h00, 1'b0);
        chk({5'h00, op_resume, busy, write_enable_latch}, 8'h07);
        wait_idle();
    endtask

    // last scenario: the engine keeps counting after the reset command
    task automatic t_sw_reset;
        send(CMD_VWREN, 8'h00, 1'b0);
        send(CMD_WR_RWL, 8'h25, 1'b0);
        send(CMD_WREN, 8'h00, 1'b0);
        send(CMD_PROG, 8'h00, 1'b0);
        send(CMD_SW_RESET, 8'h00, 1'b0);
        chk({6'h00, busy, write_enable_latch}, 8'h00);
        rd(CMD_RD_RWL, 8'h70);
        rd(CMD_RD_PSP, 8'h04);
    endtask

    // ============================================
    // main sequence and watchdog
    initial begin
        ref_clk          = 1'b0;
        rst              = 1'b1;
        cmd_valid        = 1'b0;
        cmd_code         = CMD_WREN;
        cmd_wdata        = 8'h00;
        target_protected = 1'b0;
        status_guard_hi  = 1'b0;
        write_protect_n  = 1'b1;
        n_mismatch       = 0;
        n_tests          = 0;
        repeat (12) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        t_reset();
        t_latch();
        t_nv_write();
        t_guard();
        t_config();
        t_pin();
        t_ops();
        t_suspend();
        t_sw_reset();
        end_sim();
    end

    // whole run is well under 2000 cycles
    initial begin
        repeat (20000) @(posedge ref_clk);
        n_mismatch++;
        end_sim();
    end
endmodule
